//--- hw/pcmc_pkg.sv
// shared constants and types for power and conversion mode control
package pcmc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // times in ns, converted to cycles below
  localparam int unsigned BIAS_SETTLE_NS = 2000;
  localparam int unsigned SAFE_PHASE_NS = 400;
  localparam int unsigned QUIET_WARP_NS = 200;
  localparam int unsigned QUIET_NORMAL_NS = 300;
  localparam int unsigned WARP_MAX_GAP_NS = 10000;
  // least times round up
  localparam int unsigned BIAS_CYC = (BIAS_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SAFE_CYC = (SAFE_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_WARP_CYC = (QUIET_WARP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_NORMAL_CYC =
    (QUIET_NORMAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time rounds down
  localparam int unsigned WARP_MAX_GAP_CYC = (WARP_MAX_GAP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CFG_W = 16;
  localparam int unsigned MODE_BIT = 1;
  localparam int unsigned PHASE_BIT = 0;

  typedef struct packed {
    logic [13:0] misc;
    logic mode_normal;
    logic clk_phase;
  } pcmc_cfg_t;

  localparam pcmc_cfg_t CFG_DEFAULT = 16'h0002;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAFE = 2'b01,
    ST_QUIET = 2'b10
  } pcmc_state_t;
endpackage

//--- hw/pcmc_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pcmc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // pcmc_sync

//--- hw/pcmc_top.sv
// power state and conversion mode control core
// What this block does
// - power-down high enters deep sleep, ignores convert start, serial interface off.
// - deep sleep switches core regulators and voltage reference off.
// - falling power-down or reset returns core and configuration to defaults.
// - conversions start only once bias currents are established.
// - configuration bit 1 picks mode: 0 warp, 1 normal.
// - warp mode supports up to 1 MSPS aggregate throughput.
// - normal mode allows 900 kSPS and any spacing between conversions.
// - normal mode is in force after asynchronous reset.
// - busy and quiet phase last slightly longer in normal than warp mode.
// - convert-start rising edge begins conversion; further activity ignored until end.
// - busy falling ends conversion; unfinished configuration update is discarded.
// - new configuration takes effect after two further start and end events.
// - rising reset or power-down aborts conversion and floats serial result output.
`timescale 1ns/1ps
module pcmc_top
  import pcmc_pkg::*;
#(
  parameter int unsigned WARP_GAP_CYC = pcmc_pkg::WARP_MAX_GAP_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic POWER_DOWN_I,
  input wire logic DEV_RESET_I,
  input wire logic CONVERT_START_I,
  input wire pcmc_pkg::pcmc_cfg_t CFG_WORD_I,
  input wire logic CFG_DONE_I,
  input wire logic CFG_BUSY_I,
  output logic BUSY_O,
  output logic EOC_O,
  output logic HOLD_O,
  output logic SLEEP_O,
  output logic REGULATOR_EN_O,
  output logic REFERENCE_EN_O,
  output logic SERIAL_EN_O,
  output logic SERIAL_RESULT_HIZ_O,
  output logic BIAS_READY_O,
  output logic CONV_MODE_NORMAL_O,
  output logic RESULT_SUSPECT_O,
  output pcmc_pkg::pcmc_cfg_t ACTIVE_CFG_O
);
  import pcmc_pkg::*;

  logic [2:0] pin_s;
  logic power_down_s;
  logic rst_s;
  logic convert_start_s;
  logic start_prev_q;
  logic clr_prev_q;
  logic core_clr;
  logic clr_rise;
  logic start_rise;
  logic soc;
  logic eoc;
  logic phase_done;
  logic gap_over;
  logic [CNT_W-1:0] quiet_len;
  pcmc_state_t state_q, state_d;
  logic [CNT_W-1:0] ph_cnt_q;
  logic [CNT_W-1:0] bias_cnt_q;
  logic [CNT_W-1:0] gap_cnt_q;
  logic bias_ok_q;
  logic conv_normal_q;
  logic suspect_q;
  logic hiz_q;
  logic sleep_q;
  logic pend_v_q;
  logic stage_v_q;
  pcmc_cfg_t pend_q;
  pcmc_cfg_t stage_q;
  pcmc_cfg_t active_q;

  pcmc_sync #(.W(3)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .d_i({POWER_DOWN_I, DEV_RESET_I, CONVERT_START_I}),
    .q_o(pin_s)
  );

  assign power_down_s = pin_s[2];
  assign rst_s = pin_s[1];
  assign convert_start_s = pin_s[0];
  assign core_clr = power_down_s | rst_s;
  assign clr_rise = core_clr & ~clr_prev_q;
  assign start_rise = convert_start_s & ~start_prev_q;
  assign soc = start_rise & (state_q == ST_IDLE) & bias_ok_q & ~core_clr;
  assign quiet_len = active_q.mode_normal ? CNT_W'(QUIET_NORMAL_CYC) : CNT_W'(QUIET_WARP_CYC);
  assign phase_done = (ph_cnt_q == 16'h0001);
  assign eoc = (state_q == ST_QUIET) & phase_done & ~core_clr;
  assign gap_over = (gap_cnt_q >= CNT_W'(WARP_GAP_CYC));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (soc) state_d = ST_SAFE;
      ST_SAFE: if (phase_done) state_d = ST_QUIET;
      ST_QUIET: if (phase_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (core_clr) state_d = ST_IDLE;
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q <= ST_IDLE;
      ph_cnt_q <= '0;
      start_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_prev_q <= convert_start_s;
      clr_prev_q <= core_clr;
      if (soc) ph_cnt_q <= CNT_W'(SAFE_CYC);
      else if (state_q == ST_SAFE && phase_done) ph_cnt_q <= quiet_len;
      else if (ph_cnt_q != '0) ph_cnt_q <= ph_cnt_q - 16'h0001;
      if (core_clr) ph_cnt_q <= '0;
    end
  end

  // bias settling after leaving the cleared state
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bias_cnt_q <= '0;
      bias_ok_q <= 1'b0;
    end else if (core_clr) begin
      bias_cnt_q <= '0;
      bias_ok_q <= 1'b0;
    end else if (!bias_ok_q) begin
      bias_cnt_q <= bias_cnt_q + 16'h0001;
      bias_ok_q <= (bias_cnt_q == CNT_W'(BIAS_CYC - 1));
    end
  end

  // warp spacing watch, counts from each start
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      gap_cnt_q <= '0;
      suspect_q <= 1'b0;
      conv_normal_q <= 1'b1;
    end else if (core_clr) begin
      gap_cnt_q <= '0;
      suspect_q <= 1'b0;
      conv_normal_q <= 1'b1;
    end else begin
      if (soc) gap_cnt_q <= '0;
      else if (!gap_over) gap_cnt_q <= gap_cnt_q + 16'h0001;
      if (soc) begin
        conv_normal_q <= active_q.mode_normal;
        suspect_q <= ~active_q.mode_normal & gap_over;
      end
    end
  end

  // configuration pipeline, advanced only at end of conversion
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pend_q <= CFG_DEFAULT;
      pend_v_q <= 1'b0;
      stage_q <= CFG_DEFAULT;
      stage_v_q <= 1'b0;
      active_q <= CFG_DEFAULT;
    end else if (core_clr) begin
      pend_q <= CFG_DEFAULT;
      pend_v_q <= 1'b0;
      stage_q <= CFG_DEFAULT;
      stage_v_q <= 1'b0;
      active_q <= CFG_DEFAULT;
    end else begin
      if (CFG_DONE_I) begin
        pend_q <= CFG_WORD_I;
        pend_v_q <= 1'b1;
      end else if (eoc) begin
        pend_v_q <= 1'b0;
      end
      if (eoc) begin
        stage_v_q <= pend_v_q & ~CFG_BUSY_I;
        if (pend_v_q && !CFG_BUSY_I) stage_q <= pend_q;
        if (stage_v_q) active_q <= stage_q;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hiz_q <= 1'b1;
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= power_down_s;
      if (clr_rise || core_clr) hiz_q <= 1'b1;
      else hiz_q <= 1'b0;
    end
  end

  assign BUSY_O = (state_q != ST_IDLE);
  assign EOC_O = eoc;
  assign HOLD_O = (state_q != ST_IDLE);
  assign SLEEP_O = sleep_q;
  assign REGULATOR_EN_O = ~sleep_q;
  assign REFERENCE_EN_O = ~sleep_q;
  assign SERIAL_EN_O = ~sleep_q;
  assign SERIAL_RESULT_HIZ_O = hiz_q;
  assign BIAS_READY_O = bias_ok_q;
  assign CONV_MODE_NORMAL_O = active_q.mode_normal;
  assign RESULT_SUSPECT_O = suspect_q;
  assign ACTIVE_CFG_O = active_q;

  // checks
  logic [CNT_W-1:0] busy_len_q;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) busy_len_q <= '0;
    else if (soc) busy_len_q <= 16'h0001;
    else if (state_q != ST_IDLE) busy_len_q <= busy_len_q + 16'h0001;
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  property p_sleep_off;
    power_down_s |=> (SLEEP_O && !REGULATOR_EN_O && !REFERENCE_EN_O && !SERIAL_EN_O && !soc);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep outputs wrong");

  property p_defaults;
    $fell(core_clr) |-> (active_q == CFG_DEFAULT && !pend_v_q && !stage_v_q);
  endproperty
  a_defaults: assert property (p_defaults) else $error("no defaults after clear");

  property p_bias;
    soc |-> (BIAS_READY_O && bias_cnt_q == CNT_W'(BIAS_CYC));
  endproperty
  a_bias: assert property (p_bias) else $error("start before bias ready");

  property p_mode_bit;
    soc |=> (conv_normal_q == $past(ACTIVE_CFG_O[MODE_BIT]));
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("mode bit not used");

  property p_busy_len;
    eoc |-> (busy_len_q == CNT_W'(SAFE_CYC + (conv_normal_q ? QUIET_NORMAL_CYC : QUIET_WARP_CYC)));
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_ignore;
    (BUSY_O && start_rise && !eoc && !core_clr) |=>
      (BUSY_O && busy_len_q == $past(busy_len_q) + 16'h0001);
  endproperty
  a_ignore: assert property (p_ignore) else $error("start taken while busy");

  property p_start;
    soc |=> BUSY_O ##1 BUSY_O[*8];
  endproperty
  a_start: assert property (p_start) else $error("start did not hold busy");

  property p_discard;
    (eoc && CFG_BUSY_I) |=> !stage_v_q;
  endproperty
  a_discard: assert property (p_discard) else $error("unfinished update kept");

  property p_pipe;
    (!$past(eoc) && !$past(core_clr)) |-> $stable(active_q);
  endproperty
  a_pipe: assert property (p_pipe) else $error("config changed off end event");

  property p_abort;
    clr_rise |=> (!BUSY_O && SERIAL_RESULT_HIZ_O);
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");

  property p_gap;
    (soc && !active_q.mode_normal && gap_over) |=> RESULT_SUSPECT_O;
  endproperty
  a_gap: assert property (p_gap) else $error("late warp start not flagged");

  c_warp: cover property (soc && !active_q.mode_normal);
  c_normal_eoc: cover property (eoc && conv_normal_q);
  c_abort: cover property (clr_rise && BUSY_O);
  c_cfg_apply: cover property (eoc && stage_v_q);
endmodule // pcmc_top

//--- verif/pcmc_host_model.sv
// host model that pulses convert start on request
`timescale 1ns/1ps
module pcmc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  output logic convert_start_o
);
  logic [2:0] cnt_q;
  // high for a few cycles, then low, so every request is a fresh edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
      convert_start_o <= 1'b0;
    end else begin
      cnt_q <= go_i ? 3'h4 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
      convert_start_o <= go_i || cnt_q > 3'h1;
    end
  end
endmodule // pcmc_host_model

//--- verif/pcmc_top_bench.sv
// self-checking bench for power and conversion mode control
`timescale 1ns/1ps
module pcmc_top_bench;
  import pcmc_pkg::*;
  localparam int unsigned WG = 300;
  logic clk = 1'b0, rst = 1'b1, pwr_down = 1'b0, dr = 1'b0, start_pin;
  logic go = 1'b0, cd = 1'b0, cb = 1'b0;
  logic busy, eoc, hold, slp, reg_en, ref_en, ser_en, hiz, bias, mode_n, susp;
  pcmc_cfg_t cw = CFG_DEFAULT, act_o;
  logic [15:0] act = CFG_DEFAULT, st, pw;
  logic [31:0] seed = 32'hDD52C358;
  bit pv = 0, sv = 0;
  int miscompares = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  pcmc_host_model host (.clk_i(clk), .rst_i(rst), .go_i(go), .convert_start_o(start_pin));
  pcmc_top #(.WARP_GAP_CYC(WG)) DUT (.REF_CLK_I(clk), .RESET_I(rst),
    .POWER_DOWN_I(pwr_down), .DEV_RESET_I(dr), .CONVERT_START_I(start_pin),
    .CFG_WORD_I(cw), .CFG_DONE_I(cd),
    .CFG_BUSY_I(cb), .BUSY_O(busy), .EOC_O(eoc), .HOLD_O(hold), .SLEEP_O(slp),
    .REGULATOR_EN_O(reg_en), .REFERENCE_EN_O(ref_en), .SERIAL_EN_O(ser_en),
    .SERIAL_RESULT_HIZ_O(hiz), .BIAS_READY_O(bias), .CONV_MODE_NORMAL_O(mode_n),
    .RESULT_SUSPECT_O(susp), .ACTIVE_CFG_O(act_o));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic kick;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic waitb;
    int t;
    t = 0;
    while (bias !== 1'b1 && t < 700) begin
      cyc(1);
      t++;
    end
    chk("bias_ready", 1, bias);
  endtask
  task automatic cfgw(input logic m);
    seed = xs(seed);
    pw = {seed[15:2], m, seed[0]};
    @(posedge clk);
    cw <= pw;
    cd <= 1'b1;
    @(posedge clk);
    cd <= 1'b0;
    pv = 1;
  endtask
  // one conversion; dbl retriggers mid-conversion, es is the expected suspect flag
  task automatic conv(input bit dbl, input logic es);
    int t, len, neoc;
    t = 0;
    len = 0;
    neoc = 0;
    kick();
    while (busy !== 1'b1 && t < 20) begin
      cyc(1);
      t++;
    end
    while (busy === 1'b1 && len < 400) begin
      if (dbl && len == 30) go <= 1'b1;
      if (dbl && len == 31) go <= 1'b0;
      if (len == 5) chk("suspect", es, susp);
      if (len == 5) chk("hold", 1, hold);
      if (len == 5) chk("hiz_idle", 0, hiz);
      neoc += (eoc === 1'b1);
      len++;
      cyc(1);
    end
    chk("busy_len", SAFE_CYC + (act[1] ? QUIET_NORMAL_CYC : QUIET_WARP_CYC), len);
    chk("eoc_count", 1, neoc);
    if (sv) act = st;
    sv = pv && !cb;
    st = pw;
    pv = 0;
    cyc(2);
    chk("active_cfg", act, act_o);
    chk("mode", act[1], mode_n);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk("reset_cfg", CFG_DEFAULT, act_o);
    chk("reset_mode", 1, mode_n);
    kick();
    cyc(10);
    chk("early_busy", 0, busy);
    waitb();
    conv(1, 0);
    cfgw(0);
    conv(0, 0);
    conv(0, 0);
    conv(1, 0);
    cyc(WG + 50);
    conv(0, 1);
    cfgw(1);
    @(posedge clk);
    cb <= 1'b1;
    conv(0, 0);
    @(posedge clk);
    cb <= 1'b0;
    conv(0, 0);
    for (int k = 0; k < 2; k++) begin
      cfgw(0);
      conv(0, 0);
      conv(0, 0);
      kick();
      cyc(30);
      @(posedge clk);
      if (k == 1) pwr_down <= 1'b1;
      else dr <= 1'b1;
      cyc(4);
      chk("abort_busy", 0, busy);
      chk("hiz", 1, hiz);
      chk("sleep", k, slp);
      chk("enables", k ? 3'h0 : 3'h7, {reg_en, ref_en, ser_en});
      kick();
      cyc(10);
      chk("ignored_start", 0, busy);
      @(posedge clk);
      pwr_down <= 1'b0;
      dr <= 1'b0;
      act = CFG_DEFAULT;
      pv = 0;
      sv = 0;
      cyc(4);
      chk("cleared_cfg", CFG_DEFAULT, act_o);
      waitb();
    end
    cfgw(0);
    conv(0, 0);
    conv(0, 0);
    conv(1, 0);
    end_of_test();
  end
  initial begin
    cyc(30000);
    miscompares++;
    end_of_test();
  end
endmodule // pcmc_top_bench
